//--- rtl/sem_port_ctrl.sv
// controller that drives one port of a dual-port semaphore bank
`timescale 1ns/1ns
`include "sem_ctrl_defines.svh"
// What this block does
// - flags active low: write zero to request, one to release
// - semaphore select low, then index, output enable, read/write as plain memory
// - polling port must deassert select or output enable between reads
// - acquire by writing zero then reading back; zero means owned
// - after a failed request, keep re-reading or write one
// - at power-up write one to every semaphore
// - hold memory chip select high during semaphore accesses
module sem_port_ctrl (
   input  wire logic                 clk_sys,
   input  wire logic                 srst,
   input  wire logic                 cmd_valid,
   input  wire logic [1:0]           cmd_op,
   input  wire logic [2:0]           cmd_index,
   output logic                      cmd_ready,
   output logic                      done,
   output logic                      ok,
   output logic [7:0]                owned,
   output logic                      ce_n,
   output logic                      semaphore_select_n,
   output logic                      oe_n,
   output logic                      rw_n,
   output logic [2:0]                semaphore_index,
   output logic [`DATA_W-1:0]        data_out,
   output logic                      data_oe,
   input  wire logic [`DATA_W-1:0]   data_in
);

   // ==========================================
   // state and helpers
   function automatic logic [2:0] cyc_f(input int ns);
      cyc_f = 3'((ns + `CLK_NS - 1) / `CLK_NS);
   endfunction
   sem_ctrl_pkg::state_e   state_r, state_nxt;
   sem_ctrl_pkg::op_e      op_r, op_nxt;
   logic [2:0]             idx_r, idx_nxt;
   logic [2:0]             cnt_r, cnt_nxt;
   logic [1:0]             retry_r, retry_nxt;
   logic                   wbit_r, wbit_nxt;
   logic                   flag_r, flag_nxt;
   logic                   init_pend_r, init_pend_nxt;
   logic [7:0]             owned_r, owned_nxt;
   logic                   done_r, done_nxt;
   logic                   ok_r, ok_nxt;
   logic                   ready_r, ready_nxt;
   logic                   ce_n_r;
   logic                   sel_n_r, sel_n_nxt;
   logic                   oe_n_r, oe_n_nxt;
   logic                   rw_n_r, rw_n_nxt;
   logic [2:0]             pin_idx_r;
   logic [`DATA_W-1:0]     dout_r, dout_nxt;
   logic                   doe_r, doe_nxt;
   logic [`DATA_W-1:0]     din_s1_r, din_s2_r;

   // ==========================================
   // next-state logic
   always_comb begin
      state_nxt     = state_r;
      op_nxt        = op_r;
      idx_nxt       = idx_r;
      cnt_nxt       = cnt_r + 3'd1;
      retry_nxt     = retry_r;
      wbit_nxt      = wbit_r;
      flag_nxt      = flag_r;
      init_pend_nxt = init_pend_r;
      owned_nxt     = owned_r;
      done_nxt      = 1'b0;
      ok_nxt        = ok_r;
      case (state_r)
         sem_ctrl_pkg::ST_IDLE: begin
            cnt_nxt = 3'd0;
            retry_nxt = 2'd0;
            if (init_pend_r) begin
               // free every latch from this side first
               op_nxt = sem_ctrl_pkg::OP_INIT;
               idx_nxt = `IDX_FIRST;
               wbit_nxt = 1'b1;
               state_nxt = sem_ctrl_pkg::ST_WR;
            end else if (cmd_valid && ready_r) begin
               op_nxt = sem_ctrl_pkg::op_e'(cmd_op);
               idx_nxt = cmd_index;
               case (sem_ctrl_pkg::op_e'(cmd_op))
                  sem_ctrl_pkg::OP_ACQ: begin
                     wbit_nxt = 1'b0;
                     state_nxt = sem_ctrl_pkg::ST_WR;
                  end
                  sem_ctrl_pkg::OP_REL: begin
                     wbit_nxt = 1'b1;
                     state_nxt = sem_ctrl_pkg::ST_WR;
                  end
                  sem_ctrl_pkg::OP_TEST: state_nxt = sem_ctrl_pkg::ST_RD;
                  default: init_pend_nxt = 1'b1;
               endcase
            end
         end
         sem_ctrl_pkg::ST_WR: begin
            if (cnt_r == cyc_f(`WR_PULSE_NS) - 3'd1) begin
               cnt_nxt = 3'd0;
               state_nxt = sem_ctrl_pkg::ST_WR_GAP;
            end
         end
         sem_ctrl_pkg::ST_WR_GAP: begin
            if (cnt_r == cyc_f(`GAP_NS) - 3'd1) begin
               cnt_nxt = 3'd0;
               state_nxt = sem_ctrl_pkg::ST_IDLE;
               if (op_r == sem_ctrl_pkg::OP_INIT) begin
                  if (idx_r == `IDX_LAST) begin
                     init_pend_nxt = 1'b0;
                     owned_nxt = 8'h00;
                     done_nxt = 1'b1;
                     ok_nxt = 1'b1;
                  end else begin
                     idx_nxt = idx_r + 3'd1;
                     state_nxt = sem_ctrl_pkg::ST_WR;
                  end
               end else if (op_r == sem_ctrl_pkg::OP_ACQ && !wbit_r) begin
                  state_nxt = sem_ctrl_pkg::ST_RD;
               end else begin
                  // release, or withdrawal of a failed request
                  owned_nxt[idx_r] = 1'b0;
                  done_nxt = 1'b1;
                  ok_nxt = (op_r == sem_ctrl_pkg::OP_REL);
               end
            end
         end
         sem_ctrl_pkg::ST_RD: begin
            // access time plus the input synchroniser
            if (cnt_r == cyc_f(`RD_ACCESS_NS) + `SYNC_CYC - 3'd1) begin
               cnt_nxt = 3'd0;
               flag_nxt = din_s2_r[`FLAG_BIT];
               state_nxt = sem_ctrl_pkg::ST_RD_GAP;
            end
         end
         sem_ctrl_pkg::ST_RD_GAP: begin
            if (cnt_r == cyc_f(`GAP_NS) - 3'd1) begin
               cnt_nxt = 3'd0;
               state_nxt = sem_ctrl_pkg::ST_IDLE;
               if (!flag_r) begin
                  owned_nxt[idx_r] = (op_r == sem_ctrl_pkg::OP_ACQ) | owned_r[idx_r];
                  done_nxt = 1'b1;
                  ok_nxt = 1'b1;
               end else if (op_r == sem_ctrl_pkg::OP_ACQ) begin
                  if (retry_r != `RETRY_MAX) begin
                     retry_nxt = retry_r + 2'd1;
                     state_nxt = sem_ctrl_pkg::ST_RD;
                  end else begin
                     wbit_nxt = 1'b1;
                     state_nxt = sem_ctrl_pkg::ST_WR;
                  end
               end else begin
                  done_nxt = 1'b1;
                  ok_nxt = 1'b0;
               end
            end
         end
         default: state_nxt = sem_ctrl_pkg::ST_IDLE;
      endcase
      ready_nxt = (state_nxt == sem_ctrl_pkg::ST_IDLE) && !init_pend_nxt
                  && !(cmd_valid && ready_r);
   end

   // ==========================================
   // pin drive, from the coming state
   always_comb begin
      sel_n_nxt = 1'b1;
      oe_n_nxt  = 1'b1;
      rw_n_nxt  = 1'b1;
      doe_nxt   = 1'b0;
      dout_nxt  = {`DATA_W{wbit_nxt}};
      if (state_nxt == sem_ctrl_pkg::ST_WR) begin
         sel_n_nxt = 1'b0;
         rw_n_nxt  = 1'b0;
         doe_nxt   = 1'b1;
      end else if (state_nxt == sem_ctrl_pkg::ST_RD) begin
         sel_n_nxt = 1'b0;
         oe_n_nxt  = 1'b0;
      end
   end

   // ==========================================
   // registers
   always_ff @(posedge clk_sys) begin
      din_s1_r <= data_in;
      din_s2_r <= din_s1_r;
      if (srst) begin
         state_r     <= sem_ctrl_pkg::ST_IDLE;
         op_r        <= sem_ctrl_pkg::OP_INIT;
         idx_r       <= `IDX_FIRST;
         cnt_r       <= 3'd0;
         retry_r     <= 2'd0;
         wbit_r      <= 1'b1;
         flag_r      <= 1'b1;
         init_pend_r <= 1'b1;
         owned_r     <= 8'h00;
         done_r      <= 1'b0;
         ok_r        <= 1'b0;
         ready_r     <= 1'b0;
         ce_n_r      <= 1'b1;
         sel_n_r     <= 1'b1;
         oe_n_r      <= 1'b1;
         rw_n_r      <= 1'b1;
         pin_idx_r   <= `IDX_FIRST;
         dout_r      <= {`DATA_W{1'b1}};
         doe_r       <= 1'b0;
      end else begin
         state_r     <= state_nxt;
         op_r        <= op_nxt;
         idx_r       <= idx_nxt;
         cnt_r       <= cnt_nxt;
         retry_r     <= retry_nxt;
         wbit_r      <= wbit_nxt;
         flag_r      <= flag_nxt;
         init_pend_r <= init_pend_nxt;
         owned_r     <= owned_nxt;
         done_r      <= done_nxt;
         ok_r        <= ok_nxt;
         ready_r     <= ready_nxt;
         ce_n_r      <= 1'b1;
         sel_n_r     <= sel_n_nxt;
         oe_n_r      <= oe_n_nxt;
         rw_n_r      <= rw_n_nxt;
         pin_idx_r   <= idx_nxt;
         dout_r      <= dout_nxt;
         doe_r       <= doe_nxt;
      end
   end
   assign cmd_ready          = ready_r;
   assign done               = done_r;
   assign ok                 = ok_r;
   assign owned              = owned_r;
   assign ce_n               = ce_n_r;
   assign semaphore_select_n = sel_n_r;
   assign oe_n               = oe_n_r;
   assign rw_n               = rw_n_r;
   assign semaphore_index    = pin_idx_r;
   assign data_out           = dout_r;
   assign data_oe            = doe_r;

   // ==========================================
   // checks
   property p_ce_high;
      @(posedge clk_sys) disable iff (srst) !sel_n_r |-> ce_n_r;
   endproperty
   a_ce_high: assert property (p_ce_high) else $error("memory select low");
   property p_no_rd_wr;
      @(posedge clk_sys) disable iff (srst) !sel_n_r |-> (oe_n_r || rw_n_r);
   endproperty
   a_no_rd_wr: assert property (p_no_rd_wr) else $error("read and write together");
   property p_idx_stable;
      @(posedge clk_sys) disable iff (srst) (!sel_n_r && $past(!sel_n_r)) |-> $stable(pin_idx_r);
   endproperty
   a_idx_stable: assert property (p_idx_stable) else $error("index moved mid access");
   property p_rel_one;
      @(posedge clk_sys) disable iff (srst)
         (!rw_n_r && op_r == sem_ctrl_pkg::OP_REL) |-> (doe_r && dout_r[`FLAG_BIT]);
   endproperty
   a_rel_one: assert property (p_rel_one) else $error("release not writing one");
   property p_read_gap;
      @(posedge clk_sys) disable iff (srst) !oe_n_r |-> ##[1:4] (oe_n_r && sel_n_r);
   endproperty
   a_read_gap: assert property (p_read_gap) else $error("no gap between reads");
   property p_grant_read_zero;
      @(posedge clk_sys) disable iff (srst)
         (done_r && ok_r && op_r == sem_ctrl_pkg::OP_ACQ) |-> (!flag_r && owned_r[idx_r]);
   endproperty
   a_grant_read_zero: assert property (p_grant_read_zero) else $error("bad grant");
   property p_fail_withdraw;
      @(posedge clk_sys) disable iff (srst)
         (done_r && !ok_r && op_r == sem_ctrl_pkg::OP_ACQ) |-> (wbit_r && !owned_r[idx_r]);
   endproperty
   a_fail_withdraw: assert property (p_fail_withdraw) else $error("failed request left");
   property p_init_blocks;
      @(posedge clk_sys) disable iff (srst) init_pend_r |-> !ready_r;
   endproperty
   a_init_blocks: assert property (p_init_blocks) else $error("ready during init");
   property p_standby;
      @(posedge clk_sys) disable iff (srst)
         (state_r == sem_ctrl_pkg::ST_IDLE) |-> (sel_n_r && ce_n_r && !doe_r);
   endproperty
   a_standby: assert property (p_standby) else $error("port not in standby");
endmodule // sem_port_ctrl

//--- shared/sem_ctrl_defines.svh
// timing and field constants for the semaphore port controller
`ifndef SEM_CTRL_DEFINES_SVH
`define SEM_CTRL_DEFINES_SVH

// ==========================================
// clock and pin timing, in ns; synchroniser depth in cycles
`define CLK_NS        50
`define WR_PULSE_NS   100
`define RD_ACCESS_NS  100
`define GAP_NS        50
`define SYNC_CYC      3'd2

// ==========================================
// counts and widths
`define RETRY_MAX     2'd3
`define IDX_LAST      3'd7
`define IDX_FIRST     3'd0
`define DATA_W        16
`define FLAG_BIT      0

`endif

//--- shared/sem_ctrl_pkg.sv
// types for the semaphore port controller
package sem_ctrl_pkg;

   // ==========================================
   // controller states
   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,
      ST_WR     = 3'b001,
      ST_WR_GAP = 3'b010,
      ST_RD     = 3'b011,
      ST_RD_GAP = 3'b100
   } state_e;

   // ==========================================
   // user commands
   typedef enum logic [1:0] {
      OP_ACQ  = 2'b00,
      OP_REL  = 2'b01,
      OP_TEST = 2'b10,
      OP_INIT = 2'b11
   } op_e;

endpackage

//--- tb/sem_bank_model.sv
// behavioural two-port semaphore bank, left port on the controller
`timescale 1ns/1ns
module sem_bank_model (
   input  wire logic        ce_l_n,
   input  wire logic        sel_l_n,
   input  wire logic        oe_l_n,
   input  wire logic        rw_l_n,
   input  wire logic [2:0]  idx_l,
   input  wire logic [15:0] dw_l,
   input  wire logic        doe_l,
   output logic      [15:0] dr_l,
   input  wire logic        sel_r_n,
   input  wire logic        oe_r_n,
   input  wire logic        rw_r_n,
   input  wire logic [2:0]  idx_r,
   input  wire logic        dw_r,
   output logic             dr_r
);
   // ==========================================
   // request latches, zero means request; owner 0 none, 1 left, 2 right
   // no path to any memory or other resource
   logic       req_l [8];
   logic       req_r [8];
   logic [1:0] tok   [8];
   logic       lat_l;
   logic       lat_r;
   logic       wl;
   logic       wr;
   logic       rl;
   logic       rr;

   assign wl = ~sel_l_n & ~rw_l_n & ce_l_n;
   assign rl = ~sel_l_n & ~oe_l_n & rw_l_n & ce_l_n;
   assign wr = ~sel_r_n & ~rw_r_n;
   assign rr = ~sel_r_n & ~oe_r_n & rw_r_n;

   task automatic settle(input int i);
      if (tok[i] == 2'h1 && req_l[i]) tok[i] = req_r[i] ? 2'h0 : 2'h2;
      else if (tok[i] == 2'h2 && req_r[i]) tok[i] = req_l[i] ? 2'h0 : 2'h1;
      if (tok[i] == 2'h0) tok[i] = !req_l[i] ? 2'h1 : (!req_r[i] ? 2'h2 : 2'h0);
   endtask

   // ==========================================
   // power-up: left latches hold stale requests
   initial begin
      for (int i = 0; i < 8; i++) begin
         req_l[i] = 1'b0;
         req_r[i] = 1'b1;
         tok[i]   = 2'h0;
         settle(i);
      end
      lat_l = 1'b1;
      lat_r = 1'b1;
   end

   // only index lines and data bit zero matter; losing zero waits
   always @(posedge wl) begin
      #1;
      if (doe_l) req_l[idx_l] = dw_l[0];
      settle(idx_l);
   end
   always @(posedge wr) begin
      #1;
      req_r[idx_r] = dw_r;
      settle(idx_r);
   end

   // read value frozen while select and output enable stay active
   always @(posedge rl) begin
      #1;
      lat_l = (tok[idx_l] != 2'h1);
   end
   always @(posedge rr) begin
      #1;
      lat_r = (tok[idx_r] != 2'h2);
   end

   // undriven lines show the inverse of the last value
   assign dr_l = rl ? {16{lat_l}} : {16{~lat_l}};
   assign dr_r = rr ? lat_r : ~lat_r;
endmodule // sem_bank_model

//--- tb/sem_port_ctrl_tb_top.sv
// testbench for the semaphore port controller
`timescale 1ns/1ns
module sem_port_ctrl_tb_top;
   logic        clk_sys = 1'b0;
   logic        srst = 1'b1;
   logic        cmd_valid = 1'b0;
   logic [1:0]  cmd_op = 2'h0;
   logic [2:0]  cmd_index = 3'h0;
   logic        cmd_ready;
   logic        done;
   logic        ok;
   logic [7:0]  owned;
   logic        ce_n;
   logic        semaphore_select_n;
   logic        oe_n;
   logic        rw_n;
   logic [2:0]  semaphore_index;
   logic [15:0] data_out;
   logic        data_oe;
   logic [15:0] data_in;
   logic        sel_r_n = 1'b1;
   logic        oe_r_n = 1'b1;
   logic        rw_r_n = 1'b1;
   logic [2:0]  idx_r = 3'h0;
   logic        dw_r = 1'b1;
   logic        dr_r;
   logic        rd;
   int          fail_count = 0;
   int          n_tests = 0;

   always #25 clk_sys = ~clk_sys;

   sem_port_ctrl u_dut (.clk_sys(clk_sys), .srst(srst), .cmd_valid(cmd_valid),
      .cmd_op(cmd_op), .cmd_index(cmd_index), .cmd_ready(cmd_ready), .done(done), .ok(ok),
      .owned(owned), .ce_n(ce_n), .semaphore_select_n(semaphore_select_n), .oe_n(oe_n),
      .rw_n(rw_n), .semaphore_index(semaphore_index), .data_out(data_out),
      .data_oe(data_oe), .data_in(data_in));

   sem_bank_model u_dev (.ce_l_n(ce_n), .sel_l_n(semaphore_select_n), .oe_l_n(oe_n),
      .rw_l_n(rw_n), .idx_l(semaphore_index), .dw_l(data_out), .doe_l(data_oe),
      .dr_l(data_in), .sel_r_n(sel_r_n), .oe_r_n(oe_r_n), .rw_r_n(rw_r_n), .idx_r(idx_r),
      .dw_r(dw_r), .dr_r(dr_r));

   // ==========================================
   // shared tasks
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   task automatic do_cmd(input logic [1:0] op, input logic [2:0] idx, input logic exp_ok);
      int k;
      k = 0;
      @(negedge clk_sys);
      while (cmd_ready !== 1'b1 && k < 100) begin
         @(negedge clk_sys);
         k++;
      end
      cmd_valid = 1'b1;
      cmd_op = op;
      cmd_index = idx;
      @(negedge clk_sys);
      cmd_valid = 1'b0;
      k = 0;
      while (done !== 1'b1 && k < 200) begin
         @(negedge clk_sys);
         k++;
      end
      chk("done", 16'h1, {15'h0, done});
      chk("ok", {15'h0, exp_ok}, {15'h0, ok});
   endtask

   // right-port access: write when wr_en, else read into rd
   task automatic r_acc(input logic [2:0] idx, input logic wr_en, input logic b);
      @(negedge clk_sys);
      sel_r_n = 1'b0;
      rw_r_n = ~wr_en;
      oe_r_n = wr_en;
      idx_r = idx;
      dw_r = b;
      repeat (2) @(negedge clk_sys);
      rd = dr_r;
      sel_r_n = 1'b1;
      rw_r_n = 1'b1;
      oe_r_n = 1'b1;
      dw_r = ~b;
   endtask

   // ==========================================
   // pin monitor: chip select idle, replicated write data
   always @(posedge clk_sys) begin
      if (!srst && (ce_n !== 1'b1 || (data_oe && data_out !== {16{data_out[0]}}))) begin
         fail_count++;
         $display("wrong value pins expected idle select seen %b %h", ce_n, data_out);
      end
   end

   // ==========================================
   // scenarios
   task automatic t_reset_init;
      int k;
      repeat (20) @(negedge clk_sys);
      chk("ready in reset", 16'h0, {15'h0, cmd_ready});
      chk("select in reset", 16'h1, {15'h0, semaphore_select_n});
      srst = 1'b0;
      k = 0;
      while (done !== 1'b1 && k < 100) begin
         @(negedge clk_sys);
         k++;
      end
      chk("init done", 16'h1, {15'h0, done});
      chk("init ok", 16'h1, {15'h0, ok});
      chk("owned", 16'h0, {8'h0, owned});
      for (int i = 0; i < 8; i++) chk("left latch", 16'h1, {15'h0, u_dev.req_l[i]});
      $display("reset and init done");
   endtask

   task automatic t_acq_rel;
      do_cmd(sem_ctrl_pkg::OP_ACQ, 3'h3, 1'b1);
      chk("owned", 16'h8, {8'h0, owned});
      r_acc(3'h3, 1'b0, 1'b0);
      chk("right flag", 16'h1, {15'h0, rd});
      do_cmd(sem_ctrl_pkg::OP_TEST, 3'h3, 1'b1);
      do_cmd(sem_ctrl_pkg::OP_REL, 3'h3, 1'b1);
      chk("owned", 16'h0, {8'h0, owned});
      chk("owner", 16'h0, {14'h0, u_dev.tok[3]});
      $display("acquire release done");
   endtask

   task automatic t_lockout;
      r_acc(3'h5, 1'b1, 1'b0);
      do_cmd(sem_ctrl_pkg::OP_ACQ, 3'h5, 1'b0);
      chk("owned", 16'h0, {8'h0, owned});
      chk("withdrawn", 16'h1, {15'h0, u_dev.req_l[5]});
      do_cmd(sem_ctrl_pkg::OP_TEST, 3'h5, 1'b0);
      r_acc(3'h5, 1'b1, 1'b1);
      $display("lockout done");
   endtask

   task automatic t_handover;
      r_acc(3'h4, 1'b1, 1'b0);
      fork
         do_cmd(sem_ctrl_pkg::OP_ACQ, 3'h4, 1'b1);
         begin
            repeat (10) @(negedge clk_sys);
            r_acc(3'h4, 1'b1, 1'b1);
         end
      join
      chk("owned", 16'h10, {8'h0, owned});
      r_acc(3'h4, 1'b1, 1'b0);
      do_cmd(sem_ctrl_pkg::OP_REL, 3'h4, 1'b1);
      r_acc(3'h4, 1'b0, 1'b0);
      chk("right flag", 16'h0, {15'h0, rd});
      r_acc(3'h4, 1'b1, 1'b1);
      $display("handover done");
   endtask

   task automatic t_init_cmd;
      do_cmd(sem_ctrl_pkg::OP_ACQ, 3'h2, 1'b1);
      do_cmd(sem_ctrl_pkg::OP_INIT, 3'h0, 1'b1);
      chk("owned", 16'h0, {8'h0, owned});
      chk("owner", 16'h0, {14'h0, u_dev.tok[2]});
      $display("init command done");
   endtask

   initial begin
      t_reset_init();
      t_acq_rel();
      t_lockout();
      t_handover();
      t_init_cmd();
      end_of_test();
   end

   initial begin
      #(50 * 4000);
      fail_count++;
      end_of_test();
   end
endmodule // sem_port_ctrl_tb_top
